// File: bench/ato_transfer_ops_bench.sv
// self-checking bench for the accumulator transfer decoder
// assumes the design files and ato_pkg are compiled first
`timescale 1ns/100ps
module ato_transfer_ops_bench;
    import ato_pkg::*;
    logic clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic carry_flag, skip_next;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, seed;
    ato_nib_t display_control_three, display_clock_timer;
    ato_nib_t display_timer_reload, clock_control_reg, acc;
    logic [7:0] dp;
    logic [31:0] exp_q[$];
    int errors, num_checks;

    ato_transfer_ops dut (.clk(clk), .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .display_control_three(display_control_three),
        .display_clock_timer(display_clock_timer),
        .display_timer_reload(display_timer_reload),
        .clock_control_reg(clock_control_reg),
        .carry_flag(carry_flag), .skip_next(skip_next));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                want);
        end
    endtask

    task automatic print_verdict();
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one classic cycle; reads leave their expected data in the queue
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] e);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_sel_i <= 4'hf;
        wb_we_i <= w;
        wb_adr_i <= {24'h0, a};
        wb_dat_i <= d;
        if (!w) exp_q.push_back(e);
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // read data watcher
    always @(posedge clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (exp_q.size() == 0) check(wb_dat_o, 32'hffff_ffff);
            else check(wb_dat_o, exp_q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        print_verdict();
    end

    initial begin
        seed = 32'd15727;
        sys_rst <= 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
        wb_sel_i <= 4'hf;
        wb_adr_i <= 32'h0;
        wb_dat_i <= 32'h0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        check({display_control_three, display_clock_timer,
            display_timer_reload, clock_control_reg, carry_flag,
            skip_next}, 32'h0);
        bus(1'b0, ADDR_INSTR, 32'h0, 32'h0);
        bus(1'b1, 8'h20, 32'h5, 32'h0);
        bus(1'b0, 8'h20, 32'h0, 32'h0);
        bus(1'b1, ADDR_STATUS, 32'h1, 32'h0);
        for (int i = 0; i < 4; i++) begin
            acc = 4'(rnd() >> 7);
            bus(1'b1, ADDR_ACC, {28'h0, acc}, 32'h0);
            bus(1'b1, ADDR_INSTR, {22'h0, OP_DISP_CTL3}, 32'h0);
            check({28'h0, display_control_three}, {28'h0, acc});
            bus(1'b1, ADDR_INSTR, {22'h0, OP_DISP_TIMER}, 32'h0);
            check({display_clock_timer, display_timer_reload},
                {acc, acc});
            bus(1'b1, ADDR_INSTR, {22'h0, OP_CLOCK_CTL}, 32'h0);
            check({28'h0, clock_control_reg}, {28'h0, acc});
            bus(1'b0, ADDR_DISP_TIMER, 32'h0, {24'h0, acc, acc});
            bus(1'b0, ADDR_DISP_CTL3, 32'h0, {28'h0, acc});
            bus(1'b0, ADDR_CLOCK_CTL, 32'h0, {28'h0, acc});
            bus(1'b0, ADDR_STATUS, 32'h0, 32'h1);
            check({carry_flag, skip_next}, 32'h2);
        end
        for (int j = 0; j < 16; j++) begin
            dp = 8'(rnd() >> 5);
            acc = 4'(rnd() >> 9);
            bus(1'b1, ADDR_ACC, {28'h0, acc}, 32'h0);
            bus(1'b1, ADDR_DATA_PTR, {24'h0, dp}, 32'h0);
            bus(1'b1, ADDR_INSTR, {22'h0, OP_STORE_PREFIX, j[3:0]}, 32'h0);
            bus(1'b0, ADDR_DATA_PTR, 32'h0,
                {24'h0, dp[7:4] ^ j[3:0], dp[3:0]});
            bus(1'b1, ADDR_DATA_PTR, {24'h0, dp}, 32'h0);
            bus(1'b0, ADDR_RAM_DATA, 32'h0, {28'h0, acc});
            check({carry_flag, skip_next}, 32'h2);
        end
        // a pending skip eats the next instruction
        bus(1'b1, ADDR_STATUS, 32'h3, 32'h0);
        bus(1'b1, ADDR_ACC, {28'h0, ~acc}, 32'h0);
        bus(1'b1, ADDR_INSTR, {22'h0, OP_DISP_CTL3}, 32'h0);
        check({carry_flag, skip_next}, 32'h2);
        bus(1'b0, ADDR_INSTR, 32'h0, {22'h0, OP_STORE_PREFIX, 4'hf});
        bus(1'b1, ADDR_INSTR, {22'h0, OP_DISP_CTL3}, 32'h0);
        check({28'h0, display_control_three}, {28'h0, ~acc});
        // reset again in mid-run: every register returns to zero, the ram cells keep their data
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        check({display_control_three, display_clock_timer,
            display_timer_reload, clock_control_reg, carry_flag,
            skip_next}, 32'h0);
        bus(1'b0, ADDR_ACC, 32'h0, 32'h0);
        print_verdict();
    end
endmodule

// File: hw/ato_nibble_ram.sv
// nibble-wide data ram with a registered read port
// assumes synchronous active-high reset on clk
`timescale 1ns/100ps
module ato_nibble_ram (
    input wire logic clk,
    input wire logic sys_rst,
    ato_ram_if.mem port
);
    import ato_pkg::*;

    ato_nib_t cells [RAM_DEPTH];

    // write port
    always_ff @(posedge clk) begin
        if (port.we) begin
            cells[port.waddr] <= port.wdata;
        end
    end

    // registered read data
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port.rdata <= NIB_RESET;
        end else begin
            port.rdata <= cells[port.raddr];
        end
    end
endmodule

// File: hw/ato_pkg.sv
// constants and types for the accumulator transfer decoder
// assumes a 32-bit classic wishbone bus and a 25 MHz core clock
package ato_pkg;
    typedef logic [3:0] ato_nib_t;
    typedef logic [9:0] ato_word_t;
    typedef logic [7:0] ato_ram_addr_t;

    localparam int RAM_DEPTH = 256;

    localparam logic [7:0] ADDR_ACC = 8'h00;
    localparam logic [7:0] ADDR_INSTR = 8'h04;
    localparam logic [7:0] ADDR_DATA_PTR = 8'h08;
    localparam logic [7:0] ADDR_DISP_CTL3 = 8'h0c;
    localparam logic [7:0] ADDR_DISP_TIMER = 8'h10;
    localparam logic [7:0] ADDR_CLOCK_CTL = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_RAM_DATA = 8'h1c;

    // status register fields
    localparam int STAT_CARRY_BIT = 0;
    localparam int STAT_SKIP_BIT = 1;

    // opcodes
    localparam ato_word_t OP_DISP_CTL3 = 10'h20c;
    localparam ato_word_t OP_DISP_TIMER = 10'h20d;
    localparam ato_word_t OP_CLOCK_CTL = 10'h216;
    localparam logic [5:0] OP_STORE_PREFIX = 6'h2d;

    localparam ato_nib_t NIB_RESET = 4'h0;
    localparam ato_word_t WORD_RESET = 10'h000;
endpackage

// File: hw/ato_ram_if.sv
// carrier between the decoder and its nibble ram
// assumes both ends share clk
`timescale 1ns/100ps
interface ato_ram_if;
    logic we;
    ato_pkg::ato_ram_addr_t waddr;
    ato_pkg::ato_nib_t wdata;
    ato_pkg::ato_ram_addr_t raddr;
    ato_pkg::ato_nib_t rdata;
    modport ctrl (output we, waddr, wdata, raddr, input rdata);
    modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface

// File: hw/ato_transfer_ops.sv
// accumulator transfer decoder with a classic wishbone register slave
// assumes a single 25 MHz clk and synchronous reset sys_rst
//
// Function
// RL1 - opcode 1000001100 copies accumulator to display control three, one cycle
// RL2 - timer load opcode writes accumulator to timer count and reload together
// RL3 - store writes accumulator to ram at data pointer, file select xor j
// RL4 - opcode 1000010110 copies accumulator to clock control, one cycle
// RL5 - these transfers never change carry and never cause a skip
//
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/100ps
module ato_transfer_ops (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output ato_pkg::ato_nib_t display_control_three,
    output ato_pkg::ato_nib_t display_clock_timer,
    output ato_pkg::ato_nib_t display_timer_reload,
    output ato_pkg::ato_nib_t clock_control_reg,
    output logic carry_flag,
    output logic skip_next
);
    import ato_pkg::*;

    ato_ram_if ram_bus ();

    ato_nib_t acc;
    ato_nib_t file_sel;
    ato_nib_t row_sel;
    ato_word_t last_op;
    ato_word_t op;
    ato_nib_t imm_j;
    logic [7:0] offset;
    logic req;
    logic wr_fire;
    logic exec;
    logic do_ctl3;
    logic do_timer;
    logic do_store;
    logic do_clock;
    logic [31:0] next_rdata;

    ato_nibble_ram u_ram (
        .clk(clk),
        .sys_rst(sys_rst),
        .port(ram_bus.mem)
    );

    // request decode
    always_comb begin
        req = wb_cyc_i & wb_stb_i;
        offset = wb_adr_i[7:0];
        wr_fire = req & wb_we_i & wb_ack_o & wb_sel_i[0];
        op = wb_dat_i[9:0];
        imm_j = wb_dat_i[3:0];
        exec = wr_fire & wb_sel_i[1] & (offset == ADDR_INSTR) & ~skip_next;
        do_ctl3 = exec & (op == OP_DISP_CTL3);
        do_timer = exec & (op == OP_DISP_TIMER);
        do_clock = exec & (op == OP_CLOCK_CTL);
        do_store = exec & (op[9:4] == OP_STORE_PREFIX);
    end

    // ram write port, one cycle store
    always_comb begin
        ram_bus.we = do_store; // [RL3]
        ram_bus.waddr = {file_sel, row_sel};
        ram_bus.wdata = acc;
        ram_bus.raddr = {file_sel, row_sel};
    end

    // bus acknowledge, one cycle per request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
        end
    end

    // read mux
    always_comb begin
        next_rdata = 32'h0;
        if (offset == ADDR_ACC) begin
            next_rdata[3:0] = acc;
        end else if (offset == ADDR_INSTR) begin
            next_rdata[9:0] = last_op;
        end else if (offset == ADDR_DATA_PTR) begin
            next_rdata[7:0] = {file_sel, row_sel};
        end else if (offset == ADDR_DISP_CTL3) begin
            next_rdata[3:0] = display_control_three;
        end else if (offset == ADDR_DISP_TIMER) begin
            next_rdata[7:0] = {display_timer_reload, display_clock_timer};
        end else if (offset == ADDR_CLOCK_CTL) begin
            next_rdata[3:0] = clock_control_reg;
        end else if (offset == ADDR_STATUS) begin
            next_rdata[STAT_CARRY_BIT] = carry_flag;
            next_rdata[STAT_SKIP_BIT] = skip_next;
        end else if (offset == ADDR_RAM_DATA) begin
            next_rdata[3:0] = ram_bus.rdata;
        end
    end

    // read data register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wb_dat_o <= 32'h0;
        end else if (req & ~wb_ack_o & ~wb_we_i) begin
            wb_dat_o <= next_rdata;
        end else begin
            wb_dat_o <= 32'h0;
        end
    end

    // accumulator and last opcode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc <= NIB_RESET;
            last_op <= WORD_RESET;
        end else begin
            if (wr_fire & (offset == ADDR_ACC)) begin
                acc <= wb_dat_i[3:0];
            end
            if (exec) begin
                last_op <= op;
            end
        end
    end

    // data pointer, file select modified by store
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            file_sel <= NIB_RESET;
            row_sel <= NIB_RESET;
        end else if (do_store) begin
            file_sel <= file_sel ^ imm_j; // [RL3]
        end else if (wr_fire & (offset == ADDR_DATA_PTR)) begin
            file_sel <= wb_dat_i[7:4];
            row_sel <= wb_dat_i[3:0];
        end
    end

    // display control three
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            display_control_three <= NIB_RESET;
        end else if (do_ctl3) begin
            display_control_three <= acc; // [RL1]
        end
    end

    // display timer count and reload
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            display_clock_timer <= NIB_RESET;
            display_timer_reload <= NIB_RESET;
        end else if (do_timer) begin
            display_clock_timer <= acc; // [RL2]
            display_timer_reload <= acc; // [RL2]
        end
    end

    // clock control
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clock_control_reg <= NIB_RESET;
        end else if (do_clock) begin
            clock_control_reg <= acc; // [RL4]
        end
    end

    // carry and skip: only software writes, a pending skip eats one opcode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            carry_flag <= 1'b0;
            skip_next <= 1'b0;
        end else if (wr_fire & (offset == ADDR_STATUS)) begin
            carry_flag <= wb_dat_i[STAT_CARRY_BIT];
            skip_next <= wb_dat_i[STAT_SKIP_BIT];
        end else if (wr_fire & wb_sel_i[1] & (offset == ADDR_INSTR)) begin
            skip_next <= 1'b0; // [RL5]
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_ctl3_load: assert property ( // [RL1]
        do_ctl3 |=> display_control_three == $past(acc)
            && $stable(clock_control_reg))
        else $error("display control three not loaded");
    a_timer_pair: assert property ( // [RL2]
        do_timer |=> display_clock_timer == $past(acc)
            && display_timer_reload == $past(acc))
        else $error("timer count and reload differ");
    a_store_xor: assert property ( // [RL3]
        do_store |=> file_sel == ($past(file_sel) ^ $past(imm_j)))
        else $error("file select not xored");
    a_store_write: assert property ( // [RL3]
        do_store |=> u_ram.cells[$past({file_sel, row_sel})] == $past(acc))
        else $error("ram store wrong");
    a_clock_load: assert property ( // [RL4]
        do_clock |=> clock_control_reg == $past(acc)
            && $stable(display_control_three))
        else $error("clock control not loaded");
    a_carry_kept: assert property ( // [RL5]
        exec |=> $stable(carry_flag) && !skip_next)
        else $error("transfer touched carry or skip");
    a_ack_pulse: assert property (
        req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle");

    c_ctl3: cover property (do_ctl3);
    c_timer: cover property (do_timer);
    c_store: cover property (do_store ##[1:20] do_store);
    c_clock: cover property (do_clock);
endmodule
